// [rtl/gps_pkg.sv]
`default_nettype none
package gps_pkg;
  localparam int          GPS_PINS       = 32;
  localparam int          GPS_SUB_W      = 8;
  localparam int          GPS_STRIDE_W   = 7;
  localparam logic [6:0]  GPS_OFS_DIR    = 7'h00;
  localparam logic [6:0]  GPS_OFS_LEVEL  = 7'h10;
  localparam logic [6:0]  GPS_OFS_CLR    = 7'h14;
  localparam logic [6:0]  GPS_OFS_SET    = 7'h18;
  localparam logic [6:0]  GPS_OFS_INV    = 7'h1C;
  localparam logic [6:0]  GPS_OFS_IN     = 7'h20;
  localparam logic [6:0]  GPS_OFS_CTRL   = 7'h24;
  localparam logic [6:0]  GPS_OFS_PULL   = 7'h40;
  localparam logic [31:0] GPS_RST_LEVEL  = 32'h00000000;
  localparam logic [31:0] GPS_RST_IN     = 32'h40000000;
  localparam logic [31:0] GPS_RST_CTRL   = 32'h00000000;
  localparam logic [31:0] GPS_RST_DIR    = 32'h00000000;
  localparam logic [31:0] GPS_RST_PULL   = 32'h00000000;

  typedef enum logic [1:0] {
    GPS_ST_IDLE = 2'b00,
    GPS_ST_CAPT = 2'b01,
    GPS_ST_DONE = 2'b11
  } gps_state_t;

  typedef struct packed {
    logic        wr_level;
    logic        wr_clr;
    logic        wr_set;
    logic        wr_inv;
    logic [31:0] mask;
    logic [31:0] data;
  } gps_lvl_cmd_t;
endpackage
`default_nettype wire

// [rtl/gps_sampler.sv]
`timescale 1ns/1ns
`default_nettype none
module gps_sampler #(
  parameter int          W     = 8,
  parameter logic [7:0]  RESET = 8'h00
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         continuous,
  input  wire logic         demand,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] value
);
  // Whole sub-group shares one enable, so one request wakes all eight
  always_ff @(posedge clock) begin
    if (!resetn) begin
      value <= RESET[W-1:0];
    end else if (continuous || demand) begin
      value <= pin_in; // see R9 see R10
    end
  end

  sample_track_a: assert property (@(posedge clock) disable iff (!resetn) // see R9
    (continuous || demand) |=> value == $past(pin_in))
    else $error("sampler missed pin level");
  sample_hold_a: assert property (@(posedge clock) disable iff (!resetn) // see R10
    (!continuous && !demand) |=> $stable(value))
    else $error("sampler changed without request");
endmodule // gps_sampler
`default_nettype wire

// [rtl/gps_level.sv]
`timescale 1ns/1ns
`default_nettype none
module gps_level
  import gps_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire gps_pkg::gps_lvl_cmd_t cmd,
  output var  logic [31:0]           level
);
  logic [31:0] hit;
  logic [31:0] level_next;

  assign hit = cmd.data & cmd.mask; // see R3
  assign level_next = cmd.wr_level ? ((level & ~cmd.mask) | hit) :
                      cmd.wr_clr   ? (level & ~hit) :           // see R13
                      cmd.wr_set   ? (level | hit) :            // see R1
                      cmd.wr_inv   ? (level ^ hit) :            // see R4 see R6
                      level;

  // One flop bank behind all four views keeps every readback equal
  always_ff @(posedge clock) begin
    if (!resetn) begin
      level <= GPS_RST_LEVEL;
    end else begin
      level <= level_next; // see R7 see R15
    end
  end

  level_set_a: assert property (@(posedge clock) disable iff (!resetn) // see R1
    cmd.wr_set |=> ((level & $past(hit)) == $past(hit)) && ((level & ~$past(hit)) == ($past(level) & ~$past(hit))))
    else $error("set did not act on written ones only");
  level_clr_a: assert property (@(posedge clock) disable iff (!resetn) // see R13
    cmd.wr_clr |=> (level & $past(hit)) == 32'h00000000)
    else $error("clear left a bit high");
  level_inv_a: assert property (@(posedge clock) disable iff (!resetn) // see R15
    cmd.wr_inv |=> level == ($past(level) ^ $past(hit)))
    else $error("invert did not flip all selected bits together");
endmodule // gps_level
`default_nettype wire

// [rtl/gps_top.sv]
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1 - Writing one to a level-set bit sets that drive level bit.
// R2 - For a pulled input, setting its level bit selects the pull-up instead of driving.
// R3 - Zero bits written to level-set or level-invert change nothing.
// R4 - Writing one to a level-invert bit flips that drive level bit without read-modify-write.
// R5 - For a pulled input, inverting its level bit swaps pull-up and pull-down.
// R6 - One level-invert write may change any subset of pins at once.
// R7 - Level, set, clear and invert views share one storage and all read back the level.
// R8 - Groups hold up to 32 pins, each with its own register copy at a 0x80 stride.
// R9 - Each input value bit follows the low or high level its sampler sees.
// R10 - A sampler mode bit of 0 means on-demand sampling and 1 means continuous sampling.
// R11 - Any continuous request in an eight-pin sub-group makes the whole sub-group continuous.
// R12 - A level bit drives its output pin, or picks pull-up on 1 and pull-down on 0 for a pulled input.
// R13 - Writing one to a level-clear bit clears that drive level bit.
// R14 - Writes are ignored while the peripheral write guard is active; reads still work.
// R15 - All bits chosen by one invert write change in the same clock cycle.
module gps_top
  import gps_pkg::*;
#(
  parameter int GROUPS = 2,
  parameter int GBITS  = (GROUPS > 1) ? $clog2(GROUPS) : 1,
  parameter int ADDR_W = GPS_STRIDE_W + GBITS
) (
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic [ADDR_W-1:0]          avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output var  logic [31:0]                avs_readdata,
  output var  logic                       avs_waitrequest,
  input  wire logic                       peripheral_write_guard,
  input  wire logic [GROUPS*GPS_PINS-1:0] pad_in,
  output var  logic [GROUPS*GPS_PINS-1:0] pad_out,
  output var  logic [GROUPS*GPS_PINS-1:0] pad_oe,
  output var  logic [GROUPS*GPS_PINS-1:0] pull_up,
  output var  logic [GROUPS*GPS_PINS-1:0] pull_down
);
  localparam int SUBS = GPS_PINS / GPS_SUB_W;

  gps_state_t          state_reg;
  gps_state_t          state_next;
  logic                waitrequest_reg;
  logic [31:0]         readdata_reg;
  logic [GBITS-1:0]    acc_group;
  logic [6:0]          acc_ofs;
  logic                group_ok;
  logic [31:0]         be_mask;
  logic                commit;
  logic                wr_ok;
  logic [31:0]         rd_word;
  logic [31:0]         dir_reg     [GROUPS];
  logic [31:0]         pull_reg    [GROUPS];
  logic [31:0]         ctrl_reg    [GROUPS];
  logic [31:0]         level_q     [GROUPS];
  logic [31:0]         in_q        [GROUPS];
  gps_lvl_cmd_t        lvl_cmd     [GROUPS];
  logic [GROUPS-1:0]   hit_group;
  logic [GROUPS-1:0]   demand_in;
  logic [31:0]         dir_next    [GROUPS];
  logic [31:0]         pull_next   [GROUPS];
  logic [31:0]         ctrl_next   [GROUPS];

  // Address split: low seven bits pick the register, the rest the group
  assign acc_ofs   = avs_address[GPS_STRIDE_W-1:0];                    // see R8
  assign acc_group = avs_address[ADDR_W-1:GPS_STRIDE_W];               // see R8
  assign group_ok  = (32'(acc_group) < 32'(GROUPS));
  assign be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // Writes land on the edge where waitrequest is seen low
  assign commit    = (state_reg == GPS_ST_DONE) && avs_write;
  assign wr_ok     = commit && !peripheral_write_guard && group_ok;    // see R14

  // Bus handshake: request seen, one capture cycle, then the answer cycle
  always_comb begin
    case (state_reg)
      GPS_ST_IDLE: state_next = (avs_read || avs_write) ? GPS_ST_CAPT : GPS_ST_IDLE;
      GPS_ST_CAPT: state_next = GPS_ST_DONE;
      GPS_ST_DONE: state_next = GPS_ST_IDLE;
      default:     state_next = GPS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg       <= GPS_ST_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg    <= 32'h00000000;
    end else begin
      state_reg       <= state_next;
      waitrequest_reg <= (state_reg != GPS_ST_CAPT);
      if (state_reg == GPS_ST_CAPT) begin
        readdata_reg <= avs_read ? rd_word : 32'h00000000;
      end
    end
  end

  assign avs_waitrequest = waitrequest_reg;
  assign avs_readdata    = readdata_reg;

  // Read mux; unmapped offsets and absent groups read as zero
  always_comb begin
    rd_word = 32'h00000000;
    for (int g = 0; g < GROUPS; g++) begin
      if (group_ok && (32'(acc_group) == 32'(g))) begin
        if (acc_ofs == GPS_OFS_DIR) begin
          rd_word = dir_reg[g];
        end else if (acc_ofs == GPS_OFS_LEVEL || acc_ofs == GPS_OFS_CLR ||
                     acc_ofs == GPS_OFS_SET   || acc_ofs == GPS_OFS_INV) begin
          rd_word = level_q[g]; // see R7
        end else if (acc_ofs == GPS_OFS_IN) begin
          rd_word = in_q[g]; // see R9
        end else if (acc_ofs == GPS_OFS_CTRL) begin
          rd_word = ctrl_reg[g];
        end else if (acc_ofs == GPS_OFS_PULL) begin
          rd_word = pull_reg[g];
        end
      end
    end
  end

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    assign hit_group[g] = wr_ok && (32'(acc_group) == 32'(g));
    // On-demand read fires the samplers in the cycle the request is seen
    assign demand_in[g] = (state_reg == GPS_ST_IDLE) && avs_read && group_ok &&
                          (32'(acc_group) == 32'(g)) && (acc_ofs == GPS_OFS_IN); // see R10

    assign lvl_cmd[g].wr_level = hit_group[g] && (acc_ofs == GPS_OFS_LEVEL);
    assign lvl_cmd[g].wr_clr   = hit_group[g] && (acc_ofs == GPS_OFS_CLR);  // see R13
    assign lvl_cmd[g].wr_set   = hit_group[g] && (acc_ofs == GPS_OFS_SET);  // see R1
    assign lvl_cmd[g].wr_inv   = hit_group[g] && (acc_ofs == GPS_OFS_INV);  // see R4 see R14
    assign lvl_cmd[g].mask     = be_mask;
    assign lvl_cmd[g].data     = avs_writedata;

    assign dir_next[g]  = (hit_group[g] && acc_ofs == GPS_OFS_DIR) ?
                          ((dir_reg[g] & ~be_mask) | (avs_writedata & be_mask)) : dir_reg[g];
    assign pull_next[g] = (hit_group[g] && acc_ofs == GPS_OFS_PULL) ?
                          ((pull_reg[g] & ~be_mask) | (avs_writedata & be_mask)) : pull_reg[g];
    assign ctrl_next[g] = (hit_group[g] && acc_ofs == GPS_OFS_CTRL) ?
                          ((ctrl_reg[g] & ~be_mask) | (avs_writedata & be_mask)) : ctrl_reg[g]; // see R14

    gps_level u_level (
      .clock  (clock),
      .resetn (resetn),
      .cmd    (lvl_cmd[g]),
      .level  (level_q[g])
    );

    always_ff @(posedge clock) begin
      if (!resetn) begin
        dir_reg[g]  <= GPS_RST_DIR;
        pull_reg[g] <= GPS_RST_PULL;
        ctrl_reg[g] <= GPS_RST_CTRL;
      end else begin
        dir_reg[g]  <= dir_next[g];
        pull_reg[g] <= pull_next[g];
        ctrl_reg[g] <= ctrl_next[g];
      end
    end

    // Pads and pulls are registered from the live level, one cycle behind it
    always_ff @(posedge clock) begin
      if (!resetn) begin
        pad_out[g*GPS_PINS +: GPS_PINS]   <= GPS_RST_LEVEL;
        pad_oe[g*GPS_PINS +: GPS_PINS]    <= GPS_RST_DIR;
        pull_up[g*GPS_PINS +: GPS_PINS]   <= 32'h00000000;
        pull_down[g*GPS_PINS +: GPS_PINS] <= 32'h00000000;
      end else begin
        pad_out[g*GPS_PINS +: GPS_PINS]   <= level_q[g] & dir_reg[g];                  // see R12
        pad_oe[g*GPS_PINS +: GPS_PINS]    <= dir_reg[g];
        pull_up[g*GPS_PINS +: GPS_PINS]   <= ~dir_reg[g] & pull_reg[g] & level_q[g];   // see R2 see R5
        pull_down[g*GPS_PINS +: GPS_PINS] <= ~dir_reg[g] & pull_reg[g] & ~level_q[g];  // see R5 see R12
      end
    end

    for (genvar s = 0; s < SUBS; s++) begin : g_sub
      gps_sampler #(
        .W     (GPS_SUB_W),
        .RESET (GPS_RST_IN[s*GPS_SUB_W +: GPS_SUB_W])
      ) u_sampler (
        .clock      (clock),
        .resetn     (resetn),
        .continuous (|ctrl_reg[g][s*GPS_SUB_W +: GPS_SUB_W]), // see R11
        .demand     (demand_in[g]),
        .pin_in     (pad_in[g*GPS_PINS + s*GPS_SUB_W +: GPS_SUB_W]),
        .value      (in_q[g][s*GPS_SUB_W +: GPS_SUB_W])
      );
    end

    pull_sel_a: assert property (@(posedge clock) disable iff (!resetn) // see R2
      ##1 (pull_up[g*GPS_PINS +: GPS_PINS] == (~$past(dir_reg[g]) & $past(pull_reg[g]) & $past(level_q[g]))))
      else $error("pull-up does not follow level of pulled input");
    pull_swap_a: assert property (@(posedge clock) disable iff (!resetn) // see R5
      ##1 (pull_down[g*GPS_PINS +: GPS_PINS] == (~$past(dir_reg[g]) & $past(pull_reg[g]) & ~$past(level_q[g]))))
      else $error("pull-down does not follow level of pulled input");
    sub_group_a: assert property (@(posedge clock) disable iff (!resetn) // see R11
      (ctrl_reg[g][7:0] != 8'h00) |=> (in_q[g][7:0] == $past(pad_in[g*GPS_PINS +: 8])))
      else $error("sub-group not sampled continuously");
    out_drive_a: assert property (@(posedge clock) disable iff (!resetn) // see R12
      ##1 (pad_out[g*GPS_PINS +: GPS_PINS] == ($past(level_q[g]) & $past(dir_reg[g]))))
      else $error("output pin does not follow level");
    guard_hold_a: assert property (@(posedge clock) disable iff (!resetn) // see R14
      (commit && peripheral_write_guard) |=> ($stable(level_q[g]) && $stable(ctrl_reg[g])))
      else $error("write went through the guard");
  end

  sequence req_seen_s;
    (state_reg == GPS_ST_IDLE) && (avs_read || avs_write);
  endsequence
  // Waitrequest is registered, so the low cycle shows two edges after the taking edge
  sequence answer_s;
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_answer_a: assert property (@(posedge clock) disable iff (!resetn) // see R7
    req_seen_s |-> answer_s)
    else $error("answer not on the second cycle after request");
  readback_a: assert property (@(posedge clock) disable iff (!resetn) // see R7
    (state_reg == GPS_ST_CAPT && avs_read && group_ok && acc_ofs == GPS_OFS_SET)
    |=> avs_readdata == level_q[acc_group])
    else $error("set view does not read the level");
  stride_a: assert property (@(posedge clock) disable iff (!resetn) // see R8
    (wr_ok && acc_ofs == GPS_OFS_SET) |-> ($onehot(hit_group)))
    else $error("write reached more than one group");
endmodule // gps_top
`default_nettype wire

// [bench/gps_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none
module gps_pin_model #(
  parameter int N = 64
) (
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  input  wire logic [N-1:0] pull_up,
  input  wire logic [N-1:0] pull_down,
  input  wire logic [N-1:0] ext_level,
  output var  logic [N-1:0] pad_in
);
  // Both pulls on at once is a fight on the wire, so it reads as unknown
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (pull_up[i] && pull_down[i]) pad_in[i] = 1'bx;
      else if (pull_up[i]) pad_in[i] = 1'b1;
      else if (pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ext_level[i];
    end
  end
endmodule // gps_pin_model
`default_nettype wire

// [bench/tb_gps_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_gps_top;
  import gps_pkg::*;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        peripheral_write_guard = 1'b0;
  logic [63:0] ext_level = 64'h0000000000000000;
  wire  [63:0] pad_in;
  logic [63:0] pad_out;
  logic [63:0] pad_oe;
  logic [63:0] pull_up;
  logic [63:0] pull_down;
  logic [31:0] rd;
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  gps_top #(.GROUPS(2)) DUT (.clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .peripheral_write_guard(peripheral_write_guard), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up(pull_up), .pull_down(pull_down));
  gps_pin_model #(.N(64)) pins (.pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pull_up),
    .pull_down(pull_down), .ext_level(ext_level), .pad_in(pad_in));

  always #5 clock = ~clock;

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      $display("ERROR timeout expected done seen hang");
      results();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // One access; the edge first keeps a release and the next raise apart
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, 4'hF);
    chk(n, e, rd);
  endtask

  // Pads are registered behind the level, so let two edges pass
  task automatic pads();
    repeat (2) @(posedge clock);
    #1;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    rchk("level reset", 8'h10, 32'h00000000);
    rchk("ctrl reset", 8'h24, 32'h00000000);
    rchk("invert view reset", 8'h1C, 32'h00000000);
    chk("oe reset", 32'h00000000, pad_oe[31:0]);
    $display("test reset done");

    wr(8'h00, 32'h0000FFFF);
    wr(8'h18, 32'h000000A5);
    rchk("set view", 8'h18, 32'h000000A5);
    rchk("clear view", 8'h14, 32'h000000A5);
    wr(8'h18, 32'h00000000);
    rchk("set zero", 8'h10, 32'h000000A5);
    pads();
    chk("pad after set", 32'h000000A5, pad_out[31:0]);
    chk("oe after dir", 32'h0000FFFF, pad_oe[31:0]);
    wr(8'h1C, 32'h0000FF0F);
    rchk("invert many", 8'h1C, 32'h0000FFAA);
    wr(8'h1C, 32'h00000000);
    pads();
    chk("pad after invert", 32'h0000FFAA, pad_out[31:0]);
    wr(8'h14, 32'h0000F00A);
    rchk("clear", 8'h10, 32'h00000FA0);
    bus(1'b1, 8'h18, 32'hFFFFFFFF, 4'b0001);
    rchk("lane set", 8'h10, 32'h00000FFF);
    ext_level[31:16] <= 16'h5A3C;
    rchk("input value", 8'h20, 32'h5A3C0FFF);
    $display("test level done");

    wr(8'h40, 32'hFFFF0000);
    pads();
    chk("pull down", 32'hFFFF0000, pull_down[31:0]);
    wr(8'h18, 32'h00030000);
    wr(8'h1C, 32'h00050000);
    pads();
    chk("pull up", 32'h00060000, pull_up[31:0]);
    chk("pulled not driven", 32'h00000FFF, pad_out[31:0]);
    rchk("pulled input", 8'h20, 32'h00060FFF);
    $display("test pull done");

    wr(8'h98, 32'h12345678);
    rchk("group one", 8'h90, 32'h12345678);
    rchk("group zero kept", 8'h10, 32'h00060FFF);
    pads();
    chk("group one inputs", 32'h00000000, pad_out[63:32]);
    $display("test group done");

    @(posedge clock);
    peripheral_write_guard <= 1'b1;
    wr(8'h1C, 32'hFFFFFFFF);
    wr(8'h24, 32'h000000FF);
    rchk("guarded invert", 8'h10, 32'h00060FFF);
    rchk("guarded ctrl", 8'h24, 32'h00000000);
    @(posedge clock);
    peripheral_write_guard <= 1'b0;
    $display("test guard done");

    wr(8'h24, 32'h01000001);
    rchk("ctrl", 8'h24, 32'h01000001);
    wr(8'h20, 32'hFFFFFFFF);
    // Pulls off again so the upper pins follow the outside level
    wr(8'h40, 32'h00000000);
    ext_level[31:16] <= 16'hC3A5;
    rchk("input read only", 8'h20, 32'hC3A50FFF);
    rchk("unmapped", 8'h2C, 32'h00000000);
    $display("test ctrl done");
    results();
  end
endmodule // tb_gps_top
`default_nettype wire
